// [inc/ssg_pkg.sv]
package ssg_pkg;
  // timing figures and derived cycle counts at the 100 MHz clock
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned STORE_PULSE_NS = 100;
  localparam int unsigned RECALL_PULSE_NS = 450;
  localparam int unsigned STORE_TIME_MS = 10;
  localparam int unsigned STORE_PULSE_CYC =
    (STORE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RECALL_PULSE_CYC =
    (RECALL_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned STORE_BUSY_CYC =
    (STORE_TIME_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CNT_W = 20;
  localparam int unsigned STORE_WIN_ADDRS = 16;
  localparam int unsigned STORE_WIN_W = 4;
  localparam logic [15:0] STORE_BASE_RST = 16'h0000;
  localparam logic [15:0] RECALL_BASE_RST = 16'h0100;

  typedef enum logic [2:0]
  {
    SSG_IDLE = 3'b000,
    SSG_ST_PULSE = 3'b001,
    SSG_ST_BUSY = 3'b011,
    SSG_RC_PULSE = 3'b100
  } ssg_state_e;
endpackage

// [rtl/ssg_host_ctrl.sv]
`timescale 1ns/100ps
module ssg_host_ctrl #(
  parameter int unsigned STORE_BUSY = ssg_pkg::STORE_BUSY_CYC,
  parameter logic [15:0] STORE_BASE = ssg_pkg::STORE_BASE_RST,
  parameter logic [15:0] RECALL_BASE = ssg_pkg::RECALL_BASE_RST
)
(
  input wire logic ref_clk,           // system clock
  input wire logic rstn,              // sync reset, low active
  input wire logic [15:0] bus_addr,   // processor address
  input wire logic bus_sel,           // processor access strobe
  input wire logic bus_wr,            // processor write qualifier
  input wire logic pwr_good,          // async supply status, high ok
  output logic store_n,               // store pin to device
  output logic recall_n,              // recall pin to device
  output logic busy,                  // transfer under way
  output logic store_done,            // one-cycle store finished
  output logic recall_done            // one-cycle recall finished
);
  // ****************************************
  // supply status input synchroniser
  // ****************************************
  logic [1:0] pg_sync_reg, pg_sync_next;
  always_comb
  begin
    pg_sync_next = {pg_sync_reg[0], pwr_good};
  end
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
      pg_sync_reg <= 2'h0;
    else
      pg_sync_reg <= pg_sync_next;
  end
  wire logic pwr_ok = pg_sync_reg[1];

  // ****************************************
  // address decode
  // ****************************************
  function automatic logic in_win(input logic [15:0] a,
                                  input logic [15:0] base);
    in_win = (a[15:ssg_pkg::STORE_WIN_W] ==
              base[15:ssg_pkg::STORE_WIN_W]);
  endfunction
  // qualified by write so stray power-up reads never store
  wire logic st_req = bus_sel && bus_wr &&
                      in_win(bus_addr, STORE_BASE);
  wire logic rc_req = bus_sel && in_win(bus_addr, RECALL_BASE);

  // ****************************************
  // sequencer
  // ****************************************
  ssg_pkg::ssg_state_e state_reg, state_next;
  logic [ssg_pkg::CNT_W-1:0] cnt_reg, cnt_next;
  logic store_n_reg, store_n_next, recall_n_reg, recall_n_next;
  logic busy_reg, busy_next, sd_reg, sd_next, rd_reg, rd_next;

  always_comb
  begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    sd_next = 1'b0;
    rd_next = 1'b0;
    unique case (state_reg)
      ssg_pkg::SSG_IDLE:
      begin
        cnt_next = '0;
        if (pwr_ok && rc_req)
          state_next = ssg_pkg::SSG_RC_PULSE;
        else if (pwr_ok && st_req)
          state_next = ssg_pkg::SSG_ST_PULSE;
      end
      ssg_pkg::SSG_ST_PULSE:
      begin
        cnt_next = cnt_reg + 1'b1;
        if (cnt_reg == ssg_pkg::CNT_W'(ssg_pkg::STORE_PULSE_CYC - 1))
        begin
          state_next = ssg_pkg::SSG_ST_BUSY;
          cnt_next = '0;
        end
      end
      ssg_pkg::SSG_ST_BUSY:
      begin
        // hold off all device accesses; store finishes on its own
        cnt_next = cnt_reg + 1'b1;
        if (cnt_reg == ssg_pkg::CNT_W'(STORE_BUSY - 1))
        begin
          state_next = ssg_pkg::SSG_IDLE;
          sd_next = 1'b1;
        end
      end
      ssg_pkg::SSG_RC_PULSE:
      begin
        cnt_next = cnt_reg + 1'b1;
        if (cnt_reg == ssg_pkg::CNT_W'(ssg_pkg::RECALL_PULSE_CYC - 1))
        begin
          state_next = ssg_pkg::SSG_IDLE;
          rd_next = 1'b1;
        end
      end
      default:
        state_next = ssg_pkg::SSG_IDLE;
    endcase
    // unhealthy supply: both blocks asserted
    store_n_next = !pwr_ok ||
                   (state_next != ssg_pkg::SSG_ST_PULSE);
    recall_n_next = pwr_ok &&
                    (state_next != ssg_pkg::SSG_RC_PULSE);
    busy_next = (state_next != ssg_pkg::SSG_IDLE);
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      state_reg <= ssg_pkg::SSG_IDLE;
      cnt_reg <= '0;
      store_n_reg <= 1'b1;
      recall_n_reg <= 1'b0;
      busy_reg <= 1'b0;
      sd_reg <= 1'b0;
      rd_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      store_n_reg <= store_n_next;
      recall_n_reg <= recall_n_next;
      busy_reg <= busy_next;
      sd_reg <= sd_next;
      rd_reg <= rd_next;
    end
  end

  assign store_n = store_n_reg;
  assign recall_n = recall_n_reg;
  assign busy = busy_reg;
  assign store_done = sd_reg;
  assign recall_done = rd_reg;

  // ****************************************
  // pulse length monitors
  // ****************************************
  // saturating count of low cycles on a pin, cleared while high
  function automatic logic [7:0] low_count(input logic pin,
                                           input logic [7:0] cnt);
    if (pin)
      low_count = 8'h00;
    else if (cnt == 8'hff)
      low_count = cnt;
    else
      low_count = cnt + 8'h01;
  endfunction
  logic [7:0] st_low_reg, st_low_next, rc_low_reg, rc_low_next;
  always_comb
  begin
    st_low_next = low_count(store_n_reg, st_low_reg);
    rc_low_next = low_count(recall_n_reg, rc_low_reg);
  end
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      st_low_reg <= 8'h00;
      rc_low_reg <= 8'h00;
    end
    else
    begin
      st_low_reg <= st_low_next;
      rc_low_reg <= rc_low_next;
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  a_store_blocked_bad_pwr: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    !pwr_ok |=> (store_n && !recall_n))
    else $error("store not blocked on bad power");
  a_store_pulse_width: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    $rose(store_n) |-> st_low_reg >= 8'(ssg_pkg::STORE_PULSE_CYC))
    else $error("store pulse too short");
  a_recall_pulse_width: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    $fell(recall_n) && pwr_ok |-> !recall_n [*8])
    else $error("recall pulse too short");
  a_recall_pulse_len: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    recall_done |-> rc_low_reg >= 8'(ssg_pkg::RECALL_PULSE_CYC))
    else $error("recall pulse shorter than minimum");
  a_no_dual_strobe: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    !(!store_n && !recall_n && pwr_ok))
    else $error("store with recall low");
  a_store_busy_hold: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    $rose(store_n) && busy |=> busy [*8])
    else $error("busy dropped in store interval");
  a_read_no_store: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    state_reg == ssg_pkg::SSG_IDLE && pwr_ok && bus_sel && !bus_wr
    |=> store_n)
    else $error("store on a read");
  a_recall_done_pulse: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    recall_done |-> $past(state_reg) == ssg_pkg::SSG_RC_PULSE)
    else $error("recall done without recall");
  a_store_done_src: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    store_done |-> $past(state_reg) == ssg_pkg::SSG_ST_BUSY)
    else $error("store done without store");
  c_store: cover property (@(posedge ref_clk) store_done);
  c_recall: cover property (@(posedge ref_clk) recall_done);
  c_pwr_fail: cover property (@(posedge ref_clk) $fell(pwr_ok));
  c_read_store_win: cover property (@(posedge ref_clk)
    bus_sel && !bus_wr && in_win(bus_addr, STORE_BASE));
endmodule

// [testbench/ssg_dev_model.sv]
`timescale 1ns/100ps
module ssg_dev_model #(
  parameter int STORE_NS = 10000000
)
(
  input wire logic store_n,  // store pin
  input wire logic recall_n, // recall pin
  output int stores,         // stores begun
  output int recalls         // recalls begun
);
  // ************
  // shadow arrays, no data port driven while storing
  // ************
  logic [7:0] ram [16];
  logic [7:0] nv [16];
  logic st_busy = 1'b0;
  logic rc_last = 1'bx;
  initial stores = 0;
  initial recalls = 0;
  // low recall blocks store, started store ignores recall
  always @(negedge store_n)
    if (recall_n === 1'b1 && !st_busy)
    begin
      nv = ram; // whole block, arrays match, ram free after
      stores++;
      st_busy = 1'b1;
      #(STORE_NS) st_busy = 1'b0; // store done in its window
    end
  // a recall is a fall from a known high level, not the power-up settle
  always @(recall_n)
  begin
    if (recall_n === 1'b0 && rc_last === 1'b1 && !st_busy)
    begin
      ram = nv; // whole array back
      recalls++;
    end
    rc_last = recall_n;
  end
endmodule

// [testbench/shadow_ram_store_recall_guard_tb_top.sv]
`timescale 1ns/100ps
module shadow_ram_store_recall_guard_tb_top;
  logic ref_clk = 0, rstn = 0, bus_sel = 0, bus_wr = 0, pwr_good = 1;
  logic [15:0] bus_addr = 16'h0000, a;
  logic store_n, recall_n, busy, store_done, recall_done;
  int stores, recalls, fails = 0, checked = 0, st_lo, rc_lo, n_st = 0;
  int e_st, e_rc;
  int n_rc = 0, sd_n, rd_n, bz_n;
  localparam int ST_BUSY = 20;
  always #5 ref_clk = ~ref_clk;
  ssg_host_ctrl #(.STORE_BUSY(ST_BUSY)) u_ssg_host_ctrl (.ref_clk(ref_clk),
    .rstn(rstn), .bus_addr(bus_addr), .bus_sel(bus_sel), .bus_wr(bus_wr),
    .pwr_good(pwr_good), .store_n(store_n), .recall_n(recall_n),
    .busy(busy), .store_done(store_done), .recall_done(recall_done));
  ssg_dev_model #(.STORE_NS(300)) u_ssg_dev_model (.store_n(store_n),
    .recall_n(recall_n), .stores(stores), .recalls(recalls));
  // ************
  // checks and bus access
  // ************
  task chk_bit(input logic got, input logic exp);
    checked++;
    if (got !== exp)
    begin
      fails++;
      $display("MISMATCH %0t pin level", $time);
    end
  endtask
  task chk_int(input int got, input int exp);
    checked++;
    if (got != exp)
    begin
      fails++;
      $display("MISMATCH %0t count %0d want %0d", $time, got, exp);
    end
  endtask
  function automatic int exp_len(input logic [15:0] ad, input logic w,
    input logic rc);
    if (ad[15:4] == ssg_pkg::RECALL_BASE_RST[15:4])
      return rc ? int'(ssg_pkg::RECALL_PULSE_CYC) : 0;
    if (ad[15:4] == ssg_pkg::STORE_BASE_RST[15:4] && w)
      return rc ? 0 : int'(ssg_pkg::STORE_PULSE_CYC);
    return 0;
  endfunction
  task access(input logic [15:0] ad, input logic w);
    @(negedge ref_clk);
    bus_sel = 1;
    bus_addr = ad;
    bus_wr = w;
    @(negedge ref_clk);
    bus_sel = 0;
    // pins move at the taking edge, so this sample already counts
    st_lo = int'(store_n === 1'b0);
    rc_lo = int'(recall_n === 1'b0);
    bz_n = int'(busy === 1'b1);
    sd_n = int'(store_done === 1'b1);
    rd_n = int'(recall_done === 1'b1);
    repeat (80)
    begin
      @(negedge ref_clk);
      st_lo += (store_n === 1'b0);
      rc_lo += (recall_n === 1'b0);
      bz_n += (busy === 1'b1);
      sd_n += (store_done === 1'b1);
      rd_n += (recall_done === 1'b1);
    end
  endtask
  task give_verdict;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial
  begin
    void'($urandom(32'hc79a));
    repeat (4) @(negedge ref_clk);
    chk_bit(recall_n, 1'b0);
    chk_bit(store_n, 1'b1);
    rstn = 1;
    repeat (4) @(negedge ref_clk);
    chk_bit(recall_n, 1'b1);
    for (int i = 0; i < 12; i++)
    begin
      a = 16'($urandom);
      a = (i % 3 == 0) ? {12'h000, a[3:0]} :
        (i % 3 == 1) ? {12'h010, a[3:0]} : a;
      if (i == 2)
        a = 16'h0010;
      access(a, (i < 2) ? 1'b1 : (i == 3) ? 1'b0 : 1'($urandom));
      e_st = exp_len(a, bus_wr, 1'b0);
      e_rc = exp_len(a, bus_wr, 1'b1);
      n_st += (e_st > 0);
      n_rc += (e_rc > 0);
      chk_int(st_lo, e_st);
      chk_int(rc_lo, e_rc);
      chk_int(stores, n_st);
      chk_int(recalls, n_rc);
      chk_int(bz_n, (e_st > 0) ? e_st + ST_BUSY : e_rc);
      chk_int(sd_n, int'(e_st > 0));
      chk_int(rd_n, int'(e_rc > 0));
      $display("test %0d addr %h done", i, a);
    end
    pwr_good = 0;
    // let the status pass the two-stage synchroniser first
    repeat (3) @(negedge ref_clk);
    n_rc++;
    access(16'h0003, 1'b1);
    chk_int(st_lo, 0);
    chk_bit(recall_n, 1'b0);
    chk_bit(store_n, 1'b1);
    chk_int(stores, n_st);
    chk_int(recalls, n_rc);
    chk_int(bz_n, 0);
    $display("test power fail done");
    give_verdict();
  end
endmodule
